/* File: src/dagf_map.svh */
// Register offsets, field positions, reset values and timing counts of the dip and ground-fault block.
`ifndef DAGF_MAP_SVH
`define DAGF_MAP_SVH

// Word-aligned byte offsets on the register bus.
`define DAGF_OFS_CTRL 8'h00
`define DAGF_OFS_DIP 8'h04
`define DAGF_OFS_LVL 8'h08
`define DAGF_OFS_GF 8'h0c
`define DAGF_OFS_STAT 8'h10
`define DAGF_OFS_IRQ 8'h14
`define DAGF_OFS_MASK 8'h18

// Control register fields.
`define DAGF_CTRL_MODE_LSB 0
`define DAGF_CTRL_ARST_BIT 2
`define DAGF_CTRL_GFDET_BIT 3

// Dip mode encodings.
`define DAGF_MODE_OFF 2'h0
`define DAGF_MODE_ON 2'h1
`define DAGF_MODE_RCL 2'h2

// Reset values: mode off, restart off, ground fault after startup.
`define DAGF_RST_CTRL 4'h8
// Restart delay 0 s, window 0.5 s, dip duration 0.5 s.
`define DAGF_RST_DIP 24'h000505
// Dip level 70 %, restart level 90 %.
`define DAGF_RST_LVL 16'h465a
// Warn delay 0.5 s, warn level off, trip delay 0.5 s, trip level off.
`define DAGF_RST_GF 32'h05ff05ff

// Level value that switches a ground-fault comparison off.
`define DAGF_LVL_OFF 8'hff

// Interrupt status bit positions.
`define DAGF_IRQ_DIPTRIP 0
`define DAGF_IRQ_RESTART 1
`define DAGF_IRQ_GFTRIP 2
`define DAGF_IRQ_GFWARN 3

// Timebase: one tick every 100 ms on a 5 ns clock.
`define DAGF_TICK_MS 100
`define DAGF_CLK_NS 5
`define DAGF_TICK_CYCLES ((`DAGF_TICK_MS * 1000000) / `DAGF_CLK_NS)
// Ticks per second of restart delay.
`define DAGF_TICKS_PER_S 12'h00a

`endif

/* File: src/dagf_pkg.sv */
// Types shared by the dip and ground-fault protection modules.
package dagf_pkg;

  // Dip supervision states, one-hot.
  typedef enum logic [2:0] {
    DAGF_NORM = 3'b001,
    DAGF_DIP = 3'b010,
    DAGF_DELAY = 3'b100
  } dagf_st_e;

  // Number of delay timers and their slots.
  localparam int DAGF_NTMR = 5;
  localparam int DAGF_T_DUR = 0;
  localparam int DAGF_T_WIN = 1;
  localparam int DAGF_T_RST = 2;
  localparam int DAGF_T_GFT = 3;
  localparam int DAGF_T_GFW = 4;

  // Whole state of the top module.
  typedef struct packed {
    logic [7:0] volt_s1;
    logic [7:0] volt_s2;
    logic [7:0] curr_s1;
    logic [7:0] curr_s2;
    logic start_s1;
    logic start_s2;
    dagf_st_e st;
    logic [3:0] ctrl;
    logic [23:0] dip;
    logic [15:0] lvl;
    logic [31:0] gf;
    logic [3:0] irq;
    logic [3:0] mask;
    logic ack;
    logic [31:0] rdat;
    logic dip_trip;
    logic restart;
    logic gf_trip;
    logic gf_warn;
    logic irq_out;
  } dagf_top_s;

endpackage

/* File: src/dagf_tmr_if.sv */
// Link between the protection core and one of its delay timers.
`timescale 1ns/1ps
`default_nettype none
interface dagf_tmr_if;
  // Condition to time, continuously true while counting.
  logic cond;
  // Timebase tick, one cycle every 0.1 s.
  logic tick;
  // Delay in ticks.
  logic [11:0] limit;
  // High while the condition has lasted the delay.
  logic done;
  modport ctl (output cond, output tick, output limit, input done);
  modport tmr (input cond, input tick, input limit, output done);
endinterface // dagf_tmr_if
`default_nettype wire

/* File: src/dagf_tick.sv */
// Prescaler that makes the 0.1 s timebase tick.
`timescale 1ns/1ps
`default_nettype none
`include "dagf_map.svh"
module dagf_tick #(
  parameter int CYCLES = `DAGF_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // One-cycle tick.
  output logic tick_o
);
  // State: cycle counter and registered tick.
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } dagf_tick_s;
  dagf_tick_s r_ff;
  dagf_tick_s nxt_r;

  // Count up to the period and pulse once on wrap.
  always_comb begin
    nxt_r = r_ff;
    nxt_r.tick = 1'b0;
    if (r_ff.cnt >= 32'(CYCLES - 1)) begin
      nxt_r.cnt = 32'h0;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.cnt = r_ff.cnt + 32'h1;
    end
  end

  // Register the state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign tick_o = r_ff.tick;
endmodule // dagf_tick
`default_nettype wire

/* File: src/dagf_dly.sv */
// Delay timer that reports once a condition has held for a number of ticks.
`timescale 1ns/1ps
`default_nettype none
module dagf_dly (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Timer link.
  dagf_tmr_if.tmr bus
);
  // State: elapsed ticks, saturating at the limit.
  typedef struct packed {
    logic [11:0] cnt;
  } dagf_dly_s;
  dagf_dly_s r_ff;
  dagf_dly_s nxt_r;

  // Count only while the condition holds; any gap starts from zero again.
  always_comb begin
    nxt_r = r_ff;
    if (!bus.cond) begin
      nxt_r.cnt = 12'h0;
    end else if (bus.tick && (r_ff.cnt < bus.limit)) begin
      nxt_r.cnt = r_ff.cnt + 12'h1;
    end
  end

  // Register the state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // A zero limit reports at once, so a zero delay means no delay.
  assign bus.done = bus.cond && (r_ff.cnt >= bus.limit);
endmodule // dagf_dly
`default_nettype wire

/* File: src/dagf_top.sv */
// Voltage-dip supervision with autorestart and ground-fault supervision, Wishbone slave.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dagf_map.svh"
// Overview of the timing through this block, for whoever integrates it.
// Every measurement passes two flip-flops before the comparators see it.
// The protection outputs are registered once more behind the comparators.
// So a change at a measurement pin shows at a ground-fault output three edges later, and at a dip output four edges later.
// All delays are whole timebase ticks, so a delay of n ticks can finish
// anywhere between n-1 and n tick periods after its condition becomes true.
// This uncertainty is one tick period; it was traded for a single shared
// prescaler instead of one full-rate counter per timer.
// The dip sequencer has three states: normal, dip and restart delay.
// The restart window and the dip duration are timed by two timers that both
// run only in the dip state, so leaving the dip state clears them at once.
// The restart delay timer runs only in the restart delay state.
// The ground-fault timers run on their own conditions and ignore the
// dip sequencer entirely.
// Trips and warnings are not latched here; a trip that clears on its own
// leaves its trace only in the sticky interrupt status register.
// Software that needs a latched trip must read and clear that register.
// The bus answers every request after exactly one cycle, at any address.
module dagf_top #(
  parameter int TICK_CYCLES = `DAGF_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Measurement front end, percent of nominal.
  input wire logic [7:0] line_volt_pct_i,
  input wire logic [7:0] gf_curr_pct_i,
  input wire logic startup_done_i,
  // Protection outputs to motor control.
  output logic dip_trip_o,
  output logic restart_o,
  output logic gf_trip_o,
  output logic gf_warn_o,
  // Interrupt.
  output logic irq_o
);
  // Registered state and its next value.
  dagf_pkg::dagf_top_s r_ff;
  dagf_pkg::dagf_top_s nxt_r;
  // Timebase tick.
  logic tick;
  // Timer links.
  dagf_tmr_if tif[dagf_pkg::DAGF_NTMR] ();

  // Timebase shared by all timers.
  dagf_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // One identical timer per delay.
  genvar g;
  generate
    for (g = 0; g < dagf_pkg::DAGF_NTMR; g++) begin : g_tmr
      assign tif[g].tick = tick;
      dagf_dly u_dly (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bus(tif[g])
      );
    end
  endgenerate

  // Configuration fields pulled out of the registers.
  logic [1:0] mode;
  logic arst_en;
  logic gf_after_start;
  logic [7:0] dur_t;
  logic [7:0] win_t;
  logic [7:0] rdly_s;
  logic [7:0] rst_lvl;
  logic [7:0] dip_lvl;
  logic [7:0] gft_lvl;
  logic [7:0] gft_dly;
  logic [7:0] gfw_lvl;
  logic [7:0] gfw_dly;
  assign mode = r_ff.ctrl[`DAGF_CTRL_MODE_LSB +: 2];
  assign arst_en = r_ff.ctrl[`DAGF_CTRL_ARST_BIT];
  assign gf_after_start = r_ff.ctrl[`DAGF_CTRL_GFDET_BIT];
  assign dur_t = r_ff.dip[7:0];
  assign win_t = r_ff.dip[15:8];
  assign rdly_s = r_ff.dip[23:16];
  assign rst_lvl = r_ff.lvl[7:0];
  assign dip_lvl = r_ff.lvl[15:8];
  assign gft_lvl = r_ff.gf[7:0];
  assign gft_dly = r_ff.gf[15:8];
  assign gfw_lvl = r_ff.gf[23:16];
  assign gfw_dly = r_ff.gf[31:24];

  // Timer conditions and limits.
  logic gf_active;
  logic gft_cond;
  logic gfw_cond;
  assign gf_active = !gf_after_start || r_ff.start_s2;
  assign gft_cond = gf_active && (gft_lvl != `DAGF_LVL_OFF) && (r_ff.curr_s2 > gft_lvl);
  assign gfw_cond = gf_active && (gfw_lvl != `DAGF_LVL_OFF) && (r_ff.curr_s2 > gfw_lvl);

  assign tif[dagf_pkg::DAGF_T_DUR].cond = (r_ff.st == dagf_pkg::DAGF_DIP);
  assign tif[dagf_pkg::DAGF_T_DUR].limit = {4'h0, dur_t};
  assign tif[dagf_pkg::DAGF_T_WIN].cond = (r_ff.st == dagf_pkg::DAGF_DIP);
  assign tif[dagf_pkg::DAGF_T_WIN].limit = {4'h0, win_t};
  assign tif[dagf_pkg::DAGF_T_RST].cond = (r_ff.st == dagf_pkg::DAGF_DELAY);
  assign tif[dagf_pkg::DAGF_T_RST].limit = 12'({4'h0, rdly_s} * `DAGF_TICKS_PER_S);
  assign tif[dagf_pkg::DAGF_T_GFT].cond = gft_cond;
  assign tif[dagf_pkg::DAGF_T_GFT].limit = {4'h0, gft_dly};
  assign tif[dagf_pkg::DAGF_T_GFW].cond = gfw_cond;
  assign tif[dagf_pkg::DAGF_T_GFW].limit = {4'h0, gfw_dly};

  // Byte-lane merge of a write into a register word.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Bus decode helpers.
  logic bus_wr;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_dip;
  logic [31:0] wr_lvl;
  logic [31:0] wr_gf;
  logic [31:0] wr_mask;
  logic [31:0] w1c;
  logic [3:0] ev;
  // A write lands in the cycle its acknowledge is shown.
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && r_ff.ack;
  assign wr_ctrl = lane_merge({28'h0, r_ff.ctrl}, wb_dat_i, wb_sel_i);
  assign wr_dip = lane_merge({8'h0, r_ff.dip}, wb_dat_i, wb_sel_i);
  assign wr_lvl = lane_merge({16'h0, r_ff.lvl}, wb_dat_i, wb_sel_i);
  assign wr_gf = lane_merge(r_ff.gf, wb_dat_i, wb_sel_i);
  assign wr_mask = lane_merge({28'h0, r_ff.mask}, wb_dat_i, wb_sel_i);
  assign w1c = lane_merge(32'h0, wb_dat_i, wb_sel_i);

  // Next-state logic for synchronisers, dip sequencer, outputs and registers.
  always_comb begin
    nxt_r = r_ff;
    ev = 4'h0;
    // Measurements come from another domain: two flops before use.
    nxt_r.volt_s1 = line_volt_pct_i;
    nxt_r.volt_s2 = r_ff.volt_s1;
    nxt_r.curr_s1 = gf_curr_pct_i;
    nxt_r.curr_s2 = r_ff.curr_s1;
    nxt_r.start_s1 = startup_done_i;
    nxt_r.start_s2 = r_ff.start_s1;
    nxt_r.restart = 1'b0;

    // Dip sequencer.
    case (r_ff.st)
      dagf_pkg::DAGF_NORM: begin
        if ((mode != `DAGF_MODE_OFF) && (r_ff.volt_s2 < dip_lvl)) begin
          nxt_r.st = dagf_pkg::DAGF_DIP;
        end
      end
      dagf_pkg::DAGF_DIP: begin
        if (mode == `DAGF_MODE_OFF) begin
          nxt_r.st = dagf_pkg::DAGF_NORM;
        end else if (r_ff.volt_s2 >= rst_lvl) begin
          if (arst_en && !tif[dagf_pkg::DAGF_T_WIN].done) begin
            nxt_r.st = dagf_pkg::DAGF_DELAY;
          end else begin
            nxt_r.st = dagf_pkg::DAGF_NORM;
          end
        end
      end
      dagf_pkg::DAGF_DELAY: begin
        if ((mode == `DAGF_MODE_OFF) || !arst_en) begin
          nxt_r.st = dagf_pkg::DAGF_NORM;
        end else if (r_ff.volt_s2 < dip_lvl) begin
          // rapid-cycle lockout drops the restart; plain mode rearms the dip.
          nxt_r.st = (mode == `DAGF_MODE_RCL) ? dagf_pkg::DAGF_NORM : dagf_pkg::DAGF_DIP;
        end else if (tif[dagf_pkg::DAGF_T_RST].done) begin
          nxt_r.restart = 1'b1;
          nxt_r.st = dagf_pkg::DAGF_NORM;
        end
      end
      default: begin
        nxt_r.st = dagf_pkg::DAGF_NORM;
      end
    endcase

    nxt_r.dip_trip = tif[dagf_pkg::DAGF_T_DUR].done;
    nxt_r.gf_trip = tif[dagf_pkg::DAGF_T_GFT].done;
    nxt_r.gf_warn = tif[dagf_pkg::DAGF_T_GFW].done;

    // Events are the rising edges of the outputs.
    ev[`DAGF_IRQ_DIPTRIP] = nxt_r.dip_trip && !r_ff.dip_trip;
    ev[`DAGF_IRQ_RESTART] = nxt_r.restart;
    ev[`DAGF_IRQ_GFTRIP] = nxt_r.gf_trip && !r_ff.gf_trip;
    ev[`DAGF_IRQ_GFWARN] = nxt_r.gf_warn && !r_ff.gf_warn;

    // Bus: one-cycle acknowledge, dropped in the cycle after.
    nxt_r.ack = wb_cyc_i && wb_stb_i && !r_ff.ack;
    nxt_r.rdat = 32'h0;
    if (wb_cyc_i && wb_stb_i && !r_ff.ack) begin
      case (wb_adr_i)
        `DAGF_OFS_CTRL: nxt_r.rdat = {28'h0, r_ff.ctrl};
        `DAGF_OFS_DIP: nxt_r.rdat = {8'h0, r_ff.dip};
        `DAGF_OFS_LVL: nxt_r.rdat = {16'h0, r_ff.lvl};
        `DAGF_OFS_GF: nxt_r.rdat = r_ff.gf;
        `DAGF_OFS_STAT: begin
          nxt_r.rdat = {r_ff.curr_s2, r_ff.volt_s2, 5'h0, r_ff.st, r_ff.start_s2,
                        gf_active, r_ff.gf_warn, r_ff.gf_trip, 1'b0, r_ff.dip_trip,
                        2'h0};
        end
        `DAGF_OFS_IRQ: nxt_r.rdat = {28'h0, r_ff.irq};
        `DAGF_OFS_MASK: nxt_r.rdat = {28'h0, r_ff.mask};
        // Unmapped words read as zero and ignore writes.
        default: nxt_r.rdat = 32'h0;
      endcase
    end

    // Register writes.
    if (bus_wr) begin
      case (wb_adr_i)
        `DAGF_OFS_CTRL: nxt_r.ctrl = wr_ctrl[3:0];
        `DAGF_OFS_DIP: nxt_r.dip = wr_dip[23:0];
        `DAGF_OFS_LVL: nxt_r.lvl = wr_lvl[15:0];
        `DAGF_OFS_GF: nxt_r.gf = wr_gf;
        `DAGF_OFS_MASK: nxt_r.mask = wr_mask[3:0];
        default: nxt_r.ctrl = r_ff.ctrl;
      endcase
    end

    // Sticky status: a set in the clearing cycle wins over the clear.
    if (bus_wr && (wb_adr_i == `DAGF_OFS_IRQ)) begin
      nxt_r.irq = (r_ff.irq & ~w1c[3:0]) | ev;
    end else begin
      nxt_r.irq = r_ff.irq | ev;
    end
    nxt_r.irq_out = |(nxt_r.irq & nxt_r.mask);
  end

  // Register all state; reset loads the documented defaults.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '0;
      r_ff.st <= dagf_pkg::DAGF_NORM;
      r_ff.ctrl <= `DAGF_RST_CTRL;
      r_ff.dip <= `DAGF_RST_DIP;
      r_ff.lvl <= `DAGF_RST_LVL;
      r_ff.gf <= `DAGF_RST_GF;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from flops.
  assign wb_dat_o = r_ff.rdat;
  assign wb_ack_o = r_ff.ack;
  assign dip_trip_o = r_ff.dip_trip;
  assign restart_o = r_ff.restart;
  assign gf_trip_o = r_ff.gf_trip;
  assign gf_warn_o = r_ff.gf_warn;
  assign irq_o = r_ff.irq_out;
endmodule // dagf_top
`default_nettype wire

/* File: testbench/dagf_asserts.sv */
// Port-level checker of the dip and ground-fault block.
`timescale 1ns/1ps
`default_nettype none
module dagf_asserts #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Measurements and outputs.
  input wire logic [7:0] line_volt_pct_i,
  input wire logic [7:0] gf_curr_pct_i,
  input wire logic dip_trip_o,
  input wire logic restart_o,
  input wire logic gf_trip_o,
  input wire logic gf_warn_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  // A taken request is answered on the very next edge, once.
  chk_ack_next: assert property (disable iff (rst_i) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_once: assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_none: assert property (disable iff (rst_i) !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_dat_quiet: assert property (disable iff (rst_i) !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // Reset clears every output, so no stale trip survives it.
  chk_rst_quiet: assert property (rst_i |=> !(dip_trip_o | restart_o | gf_trip_o | gf_warn_o | irq_o))
    else $error("output high after reset");
  chk_restart_pulse: assert property (disable iff (rst_i) restart_o |=> !restart_o)
    else $error("restart longer than one cycle");
  chk_dip_cause: assert property (disable iff (rst_i) $rose(dip_trip_o) |-> $past(line_volt_pct_i, 3) != 8'hff)
    else $error("dip trip without low voltage");
  chk_gft_cause: assert property (disable iff (rst_i) $rose(gf_trip_o) |-> $past(gf_curr_pct_i, 3) != 8'h00)
    else $error("ground trip without current");
  chk_gfw_cause: assert property (disable iff (rst_i) $rose(gf_warn_o) |-> $past(gf_curr_pct_i, 3) != 8'h00)
    else $error("ground warning without current");
endmodule // dagf_asserts
bind dagf_top dagf_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_dat_o, .line_volt_pct_i, .gf_curr_pct_i, .dip_trip_o, .restart_o, .gf_trip_o,
  .gf_warn_o, .irq_o);
`default_nettype wire

/* File: testbench/dagf_fe_model.sv */
// Measurement front end that presents line voltage, ground current and startup state.
`timescale 1ns/1ps
`default_nettype none
module dagf_fe_model (
  // Clock.
  input wire logic clk_i,
  // Values the bench asks for.
  input wire logic [7:0] volt_set_i,
  input wire logic [7:0] curr_set_i,
  input wire logic start_set_i,
  // Measurements towards the block.
  output logic [7:0] volt_o,
  output logic [7:0] curr_o,
  output logic start_o
);
  // New readings appear only at a clock edge, like a sampled converter.
  always_ff @(posedge clk_i) begin
    volt_o <= volt_set_i;
    curr_o <= curr_set_i;
    start_o <= start_set_i;
  end
endmodule // dagf_fe_model
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench of the dip and ground-fault block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic ack;
  logic irq;
  // Requested and presented measurements.
  logic [7:0] vs = 8'h64;
  logic [7:0] cs = 8'h00;
  logic ss = 1'b0;
  logic [7:0] v;
  logic [7:0] c;
  logic s;
  // Outputs: 0 dip trip, 1 restart, 2 ground trip, 3 ground warning.
  wire logic [3:0] outs;
  int err_count = 0;
  int tests_run = 0;
  int n;
  logic [31:0] q;
  always #2.5 clk = ~clk;
  dagf_fe_model i_fe (.clk_i(clk), .volt_set_i(vs), .curr_set_i(cs), .start_set_i(ss),
    .volt_o(v), .curr_o(c), .start_o(s));
  dagf_top #(.TICK_CYCLES(10)) i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .line_volt_pct_i(v), .gf_curr_pct_i(c), .startup_done_i(s), .dip_trip_o(outs[0]),
    .restart_o(outs[1]), .gf_trip_o(outs[2]), .gf_warn_o(outs[3]), .irq_o(irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One classic cycle; the request is held until ack is seen, then dropped for a cycle.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) chk(32'h0, 32'h1);
    @(posedge clk);
  endtask
  // Counts cycles until an output rises, at most lim.
  task automatic wait_out(input int b, input int lim);
    n = 0;
    while (outs[b] !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask
  task automatic dip(input int len);
    vs <= 8'h3c;
    repeat (len) @(posedge clk);
    vs <= 8'h64;
  endtask
  task automatic t_regs;
    logic [7:0] ra [8];
    logic [31:0] rv [8];
    ra = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h10};
    rv = '{32'h8, 32'h505, 32'h465a, 32'h05ff05ff, 32'h0, 32'h0, 32'h0, 32'h00640100};
    bus(1'b1, 8'h1c, 32'hffffffff);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
    end
  endtask
  task automatic t_dip;
    bus(1'b1, 8'h00, 32'h1);
    vs <= 8'h46;
    wait_out(0, 100);
    chk(32'(n), 32'h64);
    vs <= 8'h3c;
    wait_out(0, 200);
    chk(32'(n >= 35 && n <= 70), 32'h1);
    bus(1'b1, 8'h18, 32'h1);
    bus(1'b0, 8'h14, 32'h0);
    chk({q[0], irq}, 32'h3);
    bus(1'b1, 8'h14, 32'h1);
    bus(1'b0, 8'h14, 32'h0);
    chk({q[0], irq}, 32'h0);
    vs <= 8'h64;
  endtask
  task automatic t_rst;
    bus(1'b1, 8'h00, 32'h5);
    vs <= 8'h3c;
    repeat (10) @(posedge clk);
    vs <= 8'h59;
    wait_out(1, 15);
    chk(32'(n), 32'hf);
    vs <= 8'h5a;
    wait_out(1, 30);
    chk(32'(n < 30), 32'h1);
    dip(90);
    wait_out(1, 60);
    chk(32'(n), 32'h3c);
    bus(1'b1, 8'h00, 32'h6);
    dip(20);
    wait_out(1, 30);
    chk(32'(n < 30), 32'h1);
    bus(1'b1, 8'h04, 32'h10505);
    bus(1'b1, 8'h00, 32'h5);
    dip(20);
    wait_out(1, 200);
    chk(32'(n >= 90 && n <= 125), 32'h1);
    bus(1'b1, 8'h00, 32'h4);
    vs <= 8'h3c;
    wait_out(0, 100);
    chk(32'(n), 32'h64);
    vs <= 8'h64;
    bus(1'b1, 8'h00, 32'h1);
    dip(20);
    wait_out(1, 150);
    chk(32'(n), 32'h96);
  endtask
  task automatic t_gf;
    int a;
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h0c, 32'h0114021e);
    cs <= 8'h1e;
    wait_out(2, 60);
    chk(32'(n), 32'h3c);
    cs <= 8'h28;
    wait_out(3, 60);
    chk(32'(n <= 25), 32'h1);
    wait_out(2, 60);
    chk(32'(n >= 5 && n <= 25), 32'h1);
    // Two short bursts must not add up to the two-tick trip delay.
    cs <= 8'h00;
    repeat (10) @(posedge clk);
    cs <= 8'h28;
    wait_out(2, 8);
    a = n;
    cs <= 8'h00;
    repeat (4) @(posedge clk);
    cs <= 8'h28;
    wait_out(2, 8);
    a += n;
    cs <= 8'h00;
    wait_out(2, 10);
    chk(32'(a + n), 32'h1a);
    bus(1'b1, 8'h0c, 32'h01ff02ff);
    cs <= 8'hc8;
    wait_out(3, 60);
    chk(32'(outs[3:2]), 32'h0);
    bus(1'b1, 8'h00, 32'h8);
    bus(1'b1, 8'h0c, 32'h0114021e);
    wait_out(2, 60);
    chk(32'(n), 32'h3c);
    ss <= 1'b1;
    wait_out(2, 60);
    chk(32'(n < 60), 32'h1);
  endtask
  task automatic close_out;
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_dip();
    t_rst();
    t_gf();
    close_out();
  end
  // The whole run needs under two thousand cycles; this limit cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
